// [src/asc_map.vh]
// What this block does
// - bit-order select in bits 6 and 1
// - soft reset request in bits 5 and 2
// - address 01 returns fixed read-only identifier
// - address 02 bit 3 reports speed grade
// - address FF bit 0 copies staged registers
// - mode decode; external pin overrides register
// - address 09 bit 0 enables stabilizer
// - reset loads every register with defaults
`ifndef ASC_MAP_VH
`define ASC_MAP_VH

// register addresses, 13-bit instruction field
`define ASC_ADDR_W 13
`define ASC_ADDR_PORT_CFG 13'h0000
`define ASC_ADDR_DEVICE_IDENTIFIER 13'h0001
`define ASC_ADDR_GRADE 13'h0002
`define ASC_ADDR_MODES 13'h0008
`define ASC_ADDR_CLOCK 13'h0009
`define ASC_ADDR_UPDATE 13'h00FF

// port configuration fields
`define ASC_PC_LSB_HI 6
`define ASC_PC_LSB_LO 1
`define ASC_PC_SRST_HI 5
`define ASC_PC_SRST_LO 2
`define ASC_PC_FIXED_ONES 8'h18

// reset values
`define ASC_PC_DEFAULT 8'h18
`define ASC_MODES_DEFAULT 8'h00
`define ASC_CLOCK_DEFAULT 8'h01
`define ASC_UPDATE_DEFAULT 8'h00

// writable bit masks
`define ASC_MODES_MASK 8'h27
`define ASC_CLOCK_MASK 8'h01

// field positions and encodings
`define ASC_GRADE_BIT 3
`define ASC_PIN_SEL_BIT 5
`define ASC_MODE_LSB 0
`define ASC_MODE_MSB 2
`define ASC_MODE_FULL_OFF 3'h1
`define ASC_MODE_STBY 3'h2
`define ASC_STAB_BIT 0
`define ASC_XFER_BIT 0

// instruction word layout
`define ASC_INSTR_RW 15
`define ASC_INSTR_W_HI 14
`define ASC_INSTR_W_LO 13
`define ASC_LEN_STREAM 2'h3

// frame timing counts
`define ASC_INSTR_LAST 4'hF
`define ASC_BYTE_LAST 4'h7
`define ASC_SYNC_STAGES 2

`endif

// [src/asc_spi_regs.v]
`timescale 1ns/100ps
`default_nettype none
`include "asc_map.vh"

module asc_spi_regs #(
  parameter [7:0] DEVICE_IDENTIFIER = 8'hA5, // arbitrary identifier value
  parameter [0:0] GRADE_105 = 1'b0
) (
  input wire i_clk_sys,
  input wire i_sys_rst,
  input wire i_sclk,
  input wire i_chip_select_n,
  input wire i_sdio,
  output reg o_sdio,
  output reg o_sdio_oe_n,
  input wire i_power_down_pin,
  output reg o_lsb_first,
  output reg o_soft_reset,
  output reg o_full_power_down,
  output reg o_standby,
  output reg o_duty_cycle_stabilizer,
  output reg o_transfer_done
);

  // frame states, one-hot
  localparam [2:0] ST_INSTR = 3'b001;
  localparam [2:0] ST_DATA = 3'b010;
  localparam [2:0] ST_DONE = 3'b100;

  // synchronised pins
  wire [3:0] pins_s;
  wire sclk_s;
  wire csn_s;
  wire sdio_s;
  wire pin_pd_s;

  // frame state
  reg [2:0] state_q;
  reg [3:0] bit_cnt_q;
  reg [15:0] sh_q;
  reg rw_q;
  reg [1:0] len_q;
  reg [1:0] byte_cnt_q;
  reg [`ASC_ADDR_W-1:0] addr_q;
  reg [7:0] tx_q;
  reg sclk_prev_q;

  // register bank
  reg srst_q;
  reg [7:0] modes_m_q;
  reg [7:0] clock_m_q;
  reg [7:0] modes_s_q;
  reg [7:0] clock_s_q;
  reg xfer_q;

  // combinational helpers
  wire sclk_rise;
  wire sclk_fall;
  wire [15:0] sh_next;
  wire [15:0] instr_word;
  wire [7:0] rx_byte;
  wire [`ASC_ADDR_W-1:0] addr_nxt;
  wire [`ASC_ADDR_W-1:0] instr_addr;
  wire wr_en;
  wire regs_rst;

  // reverse bit order of a byte
  function [7:0] asc_rev8;
    input [7:0] v;
    integer k;
    begin
      for (k = 0; k < 8; k = k + 1) begin
        asc_rev8[k] = v[7-k];
      end
    end
  endfunction

  // reverse bit order of the instruction word
  function [15:0] asc_rev16;
    input [15:0] v;
    integer k;
    begin
      for (k = 0; k < 16; k = k + 1) begin
        asc_rev16[k] = v[15-k];
      end
    end
  endfunction

  // read mux; unmapped addresses and open bits give zero
  function [7:0] asc_rd;
    input [`ASC_ADDR_W-1:0] a;
    input lsb;
    input srst;
    input [7:0] modes;
    input [7:0] clk;
    input xfer;
    begin
      asc_rd = 8'h00;
      case (a)
        `ASC_ADDR_PORT_CFG: begin
          asc_rd = `ASC_PC_FIXED_ONES;
          asc_rd[`ASC_PC_LSB_HI] = lsb;
          asc_rd[`ASC_PC_LSB_LO] = lsb;
          asc_rd[`ASC_PC_SRST_HI] = srst;
          asc_rd[`ASC_PC_SRST_LO] = srst;
        end
        `ASC_ADDR_DEVICE_IDENTIFIER: asc_rd = DEVICE_IDENTIFIER;
        `ASC_ADDR_GRADE: asc_rd[`ASC_GRADE_BIT] = GRADE_105;
        `ASC_ADDR_MODES: asc_rd = modes & `ASC_MODES_MASK;
        `ASC_ADDR_CLOCK: asc_rd = clk & `ASC_CLOCK_MASK;
        `ASC_ADDR_UPDATE: asc_rd[`ASC_XFER_BIT] = xfer;
        default: asc_rd = 8'h00;
      endcase
    end
  endfunction

  // pins cross into the system clock
  asc_sync #(
    .WIDTH(4)
  ) u_sync (
    .i_clk_sys(i_clk_sys),
    .i_sys_rst(i_sys_rst),
    .i_async({i_power_down_pin, i_sdio, i_chip_select_n, i_sclk}),
    .o_sync(pins_s)
  );

  assign sclk_s = pins_s[0];
  assign csn_s = pins_s[1];
  assign sdio_s = pins_s[2];
  assign pin_pd_s = pins_s[3];

  // serial clock edge detection
  assign sclk_rise = ~csn_s & sclk_s & ~sclk_prev_q;
  assign sclk_fall = ~csn_s & ~sclk_s & sclk_prev_q;

  // incoming bit order follows the bit-order select
  assign sh_next = {sh_q[14:0], sdio_s};
  assign instr_word = o_lsb_first ? asc_rev16(sh_next) : sh_next;
  assign rx_byte = o_lsb_first ? asc_rev8(sh_next[7:0]) : sh_next[7:0];
  assign instr_addr = instr_word[`ASC_ADDR_W-1:0];
  assign addr_nxt = addr_q + {{(`ASC_ADDR_W-1){1'b0}}, 1'b1};

  // a byte is written on its last rising edge
  assign wr_en = (state_q == ST_DATA) & sclk_rise & ~rw_q & (bit_cnt_q == `ASC_BYTE_LAST);
  assign regs_rst = i_sys_rst | srst_q;

  // serial clock history
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
    end
  end

  // frame sequencer: instruction, data bytes, idle till deselect
  always @(posedge i_clk_sys) begin
    if (i_sys_rst | csn_s) begin
      state_q <= ST_INSTR;
      bit_cnt_q <= 4'h0;
      sh_q <= 16'h0000;
      rw_q <= 1'b0;
      len_q <= 2'h0;
      byte_cnt_q <= 2'h0;
      addr_q <= {`ASC_ADDR_W{1'b0}};
      tx_q <= 8'h00;
    end else begin
      case (state_q)
        ST_INSTR: begin
          if (sclk_rise) begin
            sh_q <= sh_next;
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (bit_cnt_q == `ASC_INSTR_LAST) begin
              state_q <= ST_DATA;
              bit_cnt_q <= 4'h0;
              rw_q <= instr_word[`ASC_INSTR_RW];
              len_q <= instr_word[`ASC_INSTR_W_HI:`ASC_INSTR_W_LO];
              addr_q <= instr_addr;
              tx_q <= o_lsb_first ?
                asc_rev8(asc_rd(instr_addr, o_lsb_first, o_soft_reset, modes_m_q,
                  clock_m_q, xfer_q)) :
                asc_rd(instr_addr, o_lsb_first, o_soft_reset, modes_m_q, clock_m_q, xfer_q);
            end
          end
        end
        ST_DATA: begin
          if (sclk_fall & rw_q) begin
            tx_q <= {tx_q[6:0], 1'b0};
          end
          if (sclk_rise) begin
            sh_q <= sh_next;
            bit_cnt_q <= bit_cnt_q + 4'h1;
            if (bit_cnt_q == `ASC_BYTE_LAST) begin
              bit_cnt_q <= 4'h0;
              addr_q <= addr_nxt;
              byte_cnt_q <= byte_cnt_q + 2'h1;
              tx_q <= o_lsb_first ?
                asc_rev8(asc_rd(addr_nxt, o_lsb_first, o_soft_reset, modes_m_q,
                  clock_m_q, xfer_q)) :
                asc_rd(addr_nxt, o_lsb_first, o_soft_reset, modes_m_q, clock_m_q, xfer_q);
              // fixed lengths stop after one to three bytes
              if ((len_q != `ASC_LEN_STREAM) && (byte_cnt_q == len_q)) begin
                state_q <= ST_DONE;
              end
            end
          end
        end
        ST_DONE: begin
          state_q <= ST_DONE;
        end
        default: begin
          state_q <= ST_INSTR;
        end
      endcase
    end
  end

  // readback drive changes on falling serial clock
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_sdio <= 1'b0;
      o_sdio_oe_n <= 1'b1;
    end else if (csn_s | (state_q != ST_DATA) | ~rw_q) begin
      o_sdio_oe_n <= 1'b1;
    end else if (sclk_fall) begin
      o_sdio <= tx_q[7];
      o_sdio_oe_n <= 1'b0;
    end
  end

  // port configuration: takes effect at once
  always @(posedge i_clk_sys) begin
    if (regs_rst) begin
      o_lsb_first <= 1'b0;
      o_soft_reset <= 1'b0;
    end else if (wr_en && (addr_q == `ASC_ADDR_PORT_CFG)) begin
      o_lsb_first <= rx_byte[`ASC_PC_LSB_HI] | rx_byte[`ASC_PC_LSB_LO];
      o_soft_reset <= rx_byte[`ASC_PC_SRST_HI] | rx_byte[`ASC_PC_SRST_LO];
    end
  end

  // soft reset request resets the bank one cycle later
  always @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      srst_q <= 1'b0;
    end else begin
      srst_q <= o_soft_reset & ~srst_q;
    end
  end

  // staged copies written over the serial port
  always @(posedge i_clk_sys) begin
    if (regs_rst) begin
      modes_m_q <= `ASC_MODES_DEFAULT;
      clock_m_q <= `ASC_CLOCK_DEFAULT;
    end else if (wr_en) begin
      if (addr_q == `ASC_ADDR_MODES) begin
        modes_m_q <= rx_byte & `ASC_MODES_MASK;
      end
      if (addr_q == `ASC_ADDR_CLOCK) begin
        clock_m_q <= rx_byte & `ASC_CLOCK_MASK;
      end
    end
  end

  // transfer strobe self-clears after one cycle
  always @(posedge i_clk_sys) begin
    if (regs_rst) begin
      xfer_q <= 1'b0;
    end else begin
      xfer_q <= wr_en & (addr_q == `ASC_ADDR_UPDATE) & rx_byte[`ASC_XFER_BIT];
    end
  end

  // active copies loaded by the strobe
  always @(posedge i_clk_sys) begin
    if (regs_rst) begin
      modes_s_q <= `ASC_MODES_DEFAULT;
      clock_s_q <= `ASC_CLOCK_DEFAULT;
      o_transfer_done <= 1'b0;
    end else begin
      o_transfer_done <= xfer_q;
      if (xfer_q) begin
        modes_s_q <= modes_m_q;
        clock_s_q <= clock_m_q;
      end
    end
  end

  // power mode decode, external pin has priority
  always @(posedge i_clk_sys) begin
    if (regs_rst) begin
      o_full_power_down <= 1'b0;
      o_standby <= 1'b0;
      o_duty_cycle_stabilizer <= 1'b1;
    end else begin
      o_duty_cycle_stabilizer <= clock_s_q[`ASC_STAB_BIT];
      if (pin_pd_s) begin
        o_full_power_down <= ~modes_s_q[`ASC_PIN_SEL_BIT];
        o_standby <= modes_s_q[`ASC_PIN_SEL_BIT];
      end else begin
        o_full_power_down <= (modes_s_q[`ASC_MODE_MSB:`ASC_MODE_LSB] == `ASC_MODE_FULL_OFF);
        o_standby <= (modes_s_q[`ASC_MODE_MSB:`ASC_MODE_LSB] == `ASC_MODE_STBY);
      end
    end
  end

endmodule // asc_spi_regs

`default_nettype wire

// [src/asc_sync.v]
`timescale 1ns/100ps
`default_nettype none
`include "asc_map.vh"

// two-stage synchroniser, one chain per bit
module asc_sync #(
  parameter WIDTH = 1
) (
  input wire i_clk_sys,
  input wire i_sys_rst,
  input wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
      reg meta_q;
      reg sync_q;
      // first stage read only by second stage
      always @(posedge i_clk_sys) begin
        if (i_sys_rst) begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end else begin
          meta_q <= i_async[gi];
          sync_q <= meta_q;
        end
      end
      assign o_sync[gi] = sync_q;
    end
  endgenerate

endmodule // asc_sync

`default_nettype wire

// [verification/asc_host_model.sv]
`timescale 1ns/100ps
`default_nettype none
// serial host: 125 ns link clock, idle low outside frames
module asc_host_model (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_mosi,
  input wire logic i_miso
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_mosi = 1'b0;
  end
  // one frame: instruction then nb bytes (1 or 2), first byte in the low half
  task automatic xfer(input logic [15:0] ins, input logic [15:0] wd, input int nb,
                      input logic lsbf, output logic [15:0] rd);
    logic [31:0] f;
    integer k;
    integer j;
    f = 32'h00000000;
    for (k = 0; k < 16; k++) f[31-k] = lsbf ? ins[k] : ins[15-k];
    for (k = 0; k < 16; k++) f[15-k] = lsbf ? wd[k] : wd[(k & 8) + 7 - (k & 7)];
    rd = 16'h0000;
    // keep link edges clear of both system clock edges
    #1;
    o_cs_n = 1'b0;
    for (k = 0; k < 16 + 8 * nb; k++) begin
      // a released line toggles so stale data never passes
      o_mosi = (ins[15] && k > 15) ? ~o_mosi : f[31-k];
      #62.5;
      j = k - 16;
      if (k > 15) rd[lsbf ? j : (j & 8) + 7 - (j & 7)] = i_miso;
      o_sclk = 1'b1;
      #62.5;
      o_sclk = 1'b0;
    end
    #62.5 o_cs_n = 1'b1;
    #100;
  endtask
endmodule // asc_host_model
`default_nettype wire

// [verification/asc_props.sv]
`timescale 1ns/100ps
`default_nettype none
// watches the register bank pins only
module asc_props (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_sclk,
  input wire logic i_chip_select_n,
  input wire logic i_sdio,
  input wire logic o_sdio,
  input wire logic o_sdio_oe_n,
  input wire logic i_power_down_pin,
  input wire logic o_lsb_first,
  input wire logic o_soft_reset,
  input wire logic o_full_power_down,
  input wire logic o_standby,
  input wire logic o_duty_cycle_stabilizer,
  input wire logic o_transfer_done
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  // reset values hold on the edge after any reset cycle
  reset_vals_a: assert property (disable iff (1'b0) i_sys_rst |=>
    o_sdio_oe_n && !o_lsb_first && !o_soft_reset && !o_full_power_down && !o_standby
    && o_duty_cycle_stabilizer && !o_transfer_done) else $error("reset values wrong");
  mode_excl_a: assert property (!(o_full_power_down && o_standby))
    else $error("both power modes set");
  pin_over_a: assert property (i_power_down_pin [*8] |-> o_full_power_down || o_standby)
    else $error("pin ignored");
  done_pulse_a: assert property (o_transfer_done |=> !o_transfer_done)
    else $error("transfer pulse too long");
  dcs_change_a: assert property ($changed(o_duty_cycle_stabilizer) |->
    $past(o_transfer_done) || $past(o_soft_reset, 2) || $past(o_soft_reset, 3)
    || $past(o_soft_reset, 4)) else $error("stabilizer changed unasked");
  lsb_frame_a: assert property ($changed(o_lsb_first) |-> !$past(i_chip_select_n, 4))
    else $error("bit order changed outside frame");
  soft_len_a: assert property ($rose(o_soft_reset) |=> o_soft_reset ##1 !o_soft_reset)
    else $error("soft reset width wrong");
  soft_dflt_a: assert property ($fell(o_soft_reset) |->
    ##[1:3] (!o_lsb_first && o_duty_cycle_stabilizer)) else $error("soft reset no defaults");
  oe_idle_a: assert property (i_chip_select_n [*6] |-> o_sdio_oe_n)
    else $error("drives while deselected");
  // main scenarios
  cover property (o_transfer_done);
  cover property ($rose(o_soft_reset));
  cover property (!o_sdio_oe_n);
  cover property (o_standby);
endmodule // asc_props
bind asc_spi_regs asc_props chk_u (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
  .i_sclk(i_sclk), .i_chip_select_n(i_chip_select_n), .i_sdio(i_sdio), .o_sdio(o_sdio),
  .o_sdio_oe_n(o_sdio_oe_n), .i_power_down_pin(i_power_down_pin), .o_lsb_first(o_lsb_first),
  .o_soft_reset(o_soft_reset), .o_full_power_down(o_full_power_down), .o_standby(o_standby),
  .o_duty_cycle_stabilizer(o_duty_cycle_stabilizer), .o_transfer_done(o_transfer_done));
`default_nettype wire

// [verification/asc_spi_regs_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module asc_spi_regs_bench;
  localparam logic [7:0] ID = 8'h3C; // arbitrary identifier value
  logic clk, rst, pin, sclk, csn, mosi, sdo, oe_n, lsb, srst, fpd, stby, duty_cycle_stabilizer, done;
  logic order, sr_seen, done_seen;
  logic [15:0] rd;
  wire line;
  int err_total, checked, cyc, k;
  // shared data line: device wins while it drives
  assign line = oe_n ? mosi : sdo;
  asc_host_model host_u (.o_sclk(sclk), .o_cs_n(csn), .o_mosi(mosi), .i_miso(line));
  asc_spi_regs #(.DEVICE_IDENTIFIER(ID), .GRADE_105(1'b1)) dut_u (.i_clk_sys(clk), .i_sys_rst(rst),
    .i_sclk(sclk), .i_chip_select_n(csn), .i_sdio(line), .o_sdio(sdo), .o_sdio_oe_n(oe_n),
    .i_power_down_pin(pin), .o_lsb_first(lsb), .o_soft_reset(srst),
    .o_full_power_down(fpd), .o_standby(stby), .o_duty_cycle_stabilizer(duty_cycle_stabilizer),
    .o_transfer_done(done));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // sticky pulse flags and hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (done) done_seen <= 1'b1;
    if (srst) sr_seen <= 1'b1;
    if (cyc == 30000) begin
      err_total++;
      close_out();
    end
  end
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    @(negedge clk);
    host_u.xfer({3'b000, a}, {8'h00, d}, 1, order, rd);
  endtask
  task automatic rdc(input logic [12:0] a, input logic [7:0] e);
    @(negedge clk);
    host_u.xfer({3'b100, a}, 16'h0000, 1, order, rd);
    cmp8(rd[7:0], e);
  endtask
  task automatic strobe();
    done_seen = 1'b0;
    wr(13'h00FF, 8'h01);
    cmp8({7'h00, done_seen}, 8'h01);
  endtask
  task automatic close_out();
    if (err_total == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    pin = 1'b0;
    order = 1'b0;
    sr_seen = 1'b0;
    done_seen = 1'b0;
    cyc = 0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    cmp8({1'b0, oe_n, srst, done, duty_cycle_stabilizer, lsb, fpd, stby}, 8'h48);
    wr(13'h0005, 8'hFF);
    wr(13'h0001, 8'h00);
    wr(13'h0002, 8'hF7);
    rdc(13'h0000, 8'h18);
    rdc(13'h0001, ID);
    rdc(13'h0002, 8'h08);
    rdc(13'h0008, 8'h00);
    rdc(13'h0009, 8'h01);
    rdc(13'h00FF, 8'h00);
    wr(13'h0008, 8'hFF);
    rdc(13'h0008, 8'h27);
    for (k = 0; k < 4; k++) begin
      wr(13'h0008, k[7:0]);
      strobe();
      cmp8({6'h00, fpd, stby}, k == 1 ? 8'h02 : k == 2 ? 8'h01 : 8'h00);
    end
    wr(13'h0009, 8'h00);
    cmp8({7'h00, duty_cycle_stabilizer}, 8'h01);
    strobe();
    cmp8({7'h00, duty_cycle_stabilizer}, 8'h00);
    wr(13'h0008, 8'h00);
    strobe();
    @(negedge clk) pin = 1'b1;
    repeat (8) @(negedge clk);
    cmp8({6'h00, fpd, stby}, 8'h02);
    wr(13'h0008, 8'h20);
    strobe();
    cmp8({6'h00, fpd, stby}, 8'h01);
    @(negedge clk) pin = 1'b0;
    repeat (8) @(negedge clk);
    cmp8({6'h00, fpd, stby}, 8'h00);
    wr(13'h0000, 8'h42);
    cmp8({7'h00, lsb}, 8'h01);
    order = 1'b1;
    rdc(13'h0000, 8'h5A);
    rdc(13'h0009, 8'h00);
    wr(13'h0000, 8'h24);
    order = 1'b0;
    cmp8({7'h00, sr_seen}, 8'h01);
    cmp8({6'h00, duty_cycle_stabilizer, lsb}, 8'h02);
    rdc(13'h0000, 8'h18);
    rdc(13'h0009, 8'h01);
    // two-byte write, then a streamed read across both staged registers
    @(negedge clk);
    host_u.xfer({3'b001, 13'h0008}, 16'h0002, 2, order, rd);
    @(negedge clk);
    host_u.xfer({3'b111, 13'h0008}, 16'h0000, 2, order, rd);
    cmp8(rd[7:0], 8'h02);
    cmp8(rd[15:8], 8'h00);
    strobe();
    cmp8({6'h00, fpd, stby}, 8'h01);
    cmp8({7'h00, duty_cycle_stabilizer}, 8'h00);
    close_out();
  end
endmodule // asc_spi_regs_bench
`default_nettype wire
